// ### include/pfm_defines.svh
// offsets, bit positions, reset values and line indices of the pin function mux
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH

`define PFM_NUM_LINES    51
`define PFM_NUM_FUNCS    4
`define PFM_PA_LINES     32
`define PFM_PB_LINES     19

`define PFM_FN_STRIDE    12'h008
`define PFM_FN_HI_OFF    12'h004
`define PFM_OFF_OSC      12'h020
`define PFM_OFF_STATUS   12'h024

`define PFM_OSC_MAIN     0
`define PFM_OSC_SLOW     1
`define PFM_OSC_BITS     2
`define PFM_OSC_RST      2'h0
`define PFM_FN_RST       51'h0

`define PFM_ST_TEST      0
`define PFM_ST_DBG       1
`define PFM_ST_TWO_PIN   2
`define PFM_ST_DOUT      3

`define PFM_LN_TDI       0
`define PFM_LN_TDO       1
`define PFM_LN_TMS       2
`define PFM_LN_TCK       44
`define PFM_LN_DOUT      44
`define PFM_LN_XIN_MAIN  18
`define PFM_LN_XOUT_MAIN 19
`define PFM_LN_XIN_SLOW  11
`define PFM_LN_XOUT_SLOW 12

`endif

// ### include/pfm_pkg.sv
// types shared by the pin function mux
package pfm_pkg;
    typedef logic [50:0] pfm_lines_t;
    typedef logic [3:0]  pfm_fsel_t;
endpackage

// ### hw/pfm_cell.sv
// one line of the mux: priority pick among four functions, else gpio
`timescale 1ns/1ps
module pfm_cell (
    // enables and function drive
    input  wire pfm_pkg::pfm_fsel_t en,
    input  wire pfm_pkg::pfm_fsel_t fn_out,
    input  wire pfm_pkg::pfm_fsel_t fn_oe,
    // gpio controller drive
    input  wire logic               gpio_out,
    input  wire logic               gpio_oe,
    // result
    output      pfm_pkg::pfm_fsel_t sel,
    output      logic               line_out,
    output      logic               line_oe
);
    // last function listed wins
    assign sel[3] = en[3];
    assign sel[2] = en[2] & ~en[3];
    assign sel[1] = en[1] & ~(|en[3:2]);
    assign sel[0] = en[0] & ~(|en[3:1]);

    wire any_fn = |en;
    wire pick_o = |(sel & fn_out);
    wire pick_e = |(sel & fn_oe);

    assign line_out = any_fn ? pick_o : gpio_out;
    assign line_oe  = any_fn ? pick_e : gpio_oe;
endmodule // pfm_cell

// ### hw/pfm_mux.sv
// pin function mux top: apb registers, per-line muxing and pin overrides
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "pfm_defines.svh"
module pfm_mux (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output      logic [31:0]       prdata,
    output      logic              pready,
    output      logic              pslverr,
    // gpio controller
    input  wire pfm_pkg::pfm_lines_t gpio_out,
    input  wire pfm_pkg::pfm_lines_t gpio_oe,
    output      pfm_pkg::pfm_lines_t gpio_in,
    // peripheral functions a to d
    input  wire pfm_pkg::pfm_lines_t fn_a_out,
    input  wire pfm_pkg::pfm_lines_t fn_a_oe,
    output      pfm_pkg::pfm_lines_t fn_a_in,
    input  wire pfm_pkg::pfm_lines_t fn_b_out,
    input  wire pfm_pkg::pfm_lines_t fn_b_oe,
    output      pfm_pkg::pfm_lines_t fn_b_in,
    input  wire pfm_pkg::pfm_lines_t fn_c_out,
    input  wire pfm_pkg::pfm_lines_t fn_c_oe,
    output      pfm_pkg::pfm_lines_t fn_c_in,
    input  wire pfm_pkg::pfm_lines_t fn_d_out,
    input  wire pfm_pkg::pfm_lines_t fn_d_oe,
    output      pfm_pkg::pfm_lines_t fn_d_in,
    // test port
    input  wire logic              test_tdo,
    output      logic              test_port_en,
    output      logic              test_tdi,
    output      logic              test_tms,
    output      logic              test_tck,
    // debug link, single-pin or two-pin with pb12 output
    input  wire logic              dbg_link_en,
    input  wire logic              dbg_two_pin,
    input  wire logic              dbg_data_out,
    input  wire logic              dbg_data_oe,
    input  wire logic              debug_data_output,
    output      logic              dbg_data_in,
    // reset pad used as debug data
    input  wire logic              rst_pad_in,
    output      logic              rst_pad_out,
    output      logic              rst_pad_oe,
    // oscillators
    output      logic              main_crystal_en,
    output      logic              slow_crystal_en,
    // package pins
    input  wire pfm_pkg::pfm_lines_t pad_in,
    output      pfm_pkg::pfm_lines_t pad_out,
    output      pfm_pkg::pfm_lines_t pad_oe,
    output      pfm_pkg::pfm_lines_t pad_analog
);
    wire pfm_pkg::pfm_lines_t fn_en [0:3];
    logic [`PFM_OSC_BITS-1:0] osc_ctrl;
    logic                     cap_done;
    logic                     test_en;
    wire pfm_pkg::pfm_fsel_t  line_sel [0:50];
    wire pfm_pkg::pfm_lines_t cell_out;
    wire pfm_pkg::pfm_lines_t cell_oe;
    wire pfm_pkg::pfm_lines_t fn_any;

    // apb decode
    wire        setup    = psel & ~penable;
    wire        wr_go    = psel & penable & pwrite;
    wire        hit_osc  = (paddr == `PFM_OFF_OSC);
    wire        hit_stat = (paddr == `PFM_OFF_STATUS);
    wire [7:0]  hit_fn;
    wire [31:0] rd_fn  [0:7];
    wire [31:0] rd_acc [0:8];
    wire        dout_act = dbg_link_en & dbg_two_pin & ~test_en;

    assign rd_acc[0] = 32'h0;
    genvar f;
    generate
        for (f = 0; f < 4; f++) begin : g_fn
            wire [11:0] lo_addr = 12'(f) * `PFM_FN_STRIDE;
            pfm_pkg::pfm_lines_t en_r;
            assign hit_fn[2*f]   = (paddr == lo_addr);
            assign hit_fn[2*f+1] = (paddr == lo_addr + `PFM_FN_HI_OFF);
            assign rd_fn[2*f]    = fn_en[f][31:0];
            assign rd_fn[2*f+1]  = {13'h0, fn_en[f][50:32]};
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    en_r <= `PFM_FN_RST;
                end else if (wr_go && hit_fn[2*f]) begin
                    en_r[31:0] <= pwdata;
                end else if (wr_go && hit_fn[2*f+1]) begin
                    en_r[50:32] <= pwdata[18:0];
                end
            end
            assign fn_en[f] = en_r;
        end
        for (f = 0; f < 8; f++) begin : g_rd
            assign rd_acc[f+1] = rd_acc[f] | (hit_fn[f] ? rd_fn[f] : 32'h0);
        end
    endgenerate

    wire [31:0] stat_val = {28'h0, dout_act, dbg_two_pin, dbg_link_en, test_en};
    wire [31:0] rd_data  = hit_osc  ? {30'h0, osc_ctrl} :
                           hit_stat ? stat_val : rd_acc[8];
    wire        mapped   = hit_osc | hit_stat | (|hit_fn);

    assign pready = psel & penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0 : rd_data;
            pslverr <= ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_ctrl <= `PFM_OSC_RST;
        end else if (wr_go && hit_osc) begin
            osc_ctrl <= pwdata[`PFM_OSC_BITS-1:0];
        end
    end

    // tck level sampled at the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_done <= 1'b0;
            test_en  <= 1'b0;
        end else if (!cap_done) begin
            cap_done <= 1'b1;
            test_en  <= ~pad_in[`PFM_LN_TCK];
        end
    end

    // per-line function pick
    genvar i;
    generate
        for (i = 0; i < `PFM_NUM_LINES; i++) begin : g_line
            pfm_cell u_cell (
                .en       ({fn_en[3][i], fn_en[2][i], fn_en[1][i], fn_en[0][i]}),
                .fn_out   ({fn_d_out[i], fn_c_out[i], fn_b_out[i], fn_a_out[i]}),
                .fn_oe    ({fn_d_oe[i], fn_c_oe[i], fn_b_oe[i], fn_a_oe[i]}),
                .gpio_out (gpio_out[i]),
                .gpio_oe  (gpio_oe[i]),
                .sel      (line_sel[i]),
                .line_out (cell_out[i]),
                .line_oe  (cell_oe[i])
            );
            assign fn_any[i] = |line_sel[i];
        end
    endgenerate

    // override masks
    wire [50:0] one       = 51'h1;
    wire [50:0] test_mask = test_en ? ((one << `PFM_LN_TDI) | (one << `PFM_LN_TDO) |
                                       (one << `PFM_LN_TMS) | (one << `PFM_LN_TCK))
                                    : 51'h0;
    wire [50:0] dout_mask = dout_act ? (one << `PFM_LN_DOUT) : 51'h0;
    wire [50:0] osc_mask  = (osc_ctrl[`PFM_OSC_MAIN] ? ((one << `PFM_LN_XIN_MAIN) |
                             (one << `PFM_LN_XOUT_MAIN)) : 51'h0) |
                            (osc_ctrl[`PFM_OSC_SLOW] ? ((one << `PFM_LN_XIN_SLOW) |
                             (one << `PFM_LN_XOUT_SLOW)) : 51'h0);
    wire [50:0] ovr       = test_mask | dout_mask | osc_mask;
    wire [50:0] tdo_bit   = one << `PFM_LN_TDO;
    wire [50:0] dout_bit  = one << `PFM_LN_DOUT;

    // test port first, then debug output, then oscillators, then the cell
    wire [50:0] next_pad_out = test_en   ? ((cell_out & ~test_mask & ~osc_mask) |
                                            (test_tdo ? tdo_bit : 51'h0))
                                         : ((cell_out & ~ovr) |
                                            (debug_data_output ? dout_mask : 51'h0));
    wire [50:0] next_pad_oe  = (cell_oe & ~ovr) | (test_mask & tdo_bit) |
                               (dout_mask & dout_bit);
    wire [50:0] in_free      = pad_in & ~ovr;
    wire [50:0] next_gpio_in = pad_in;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out    <= 51'h0;
            pad_oe     <= 51'h0;
            pad_analog <= 51'h0;
        end else begin
            pad_out    <= next_pad_out;
            pad_oe     <= next_pad_oe;
            pad_analog <= osc_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_in <= 51'h0;
            fn_a_in <= 51'h0;
            fn_b_in <= 51'h0;
            fn_c_in <= 51'h0;
            fn_d_in <= 51'h0;
        end else begin
            gpio_in <= next_gpio_in;
            fn_a_in <= in_free & fn_en[0];
            fn_b_in <= in_free & fn_en[1];
            fn_c_in <= in_free & fn_en[2];
            fn_d_in <= in_free & fn_en[3];
        end
    end

    // test port and debug data inputs idle high like a pulled-up pin; reset pad out and oe idle low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_tdi    <= 1'b1;
            test_tms    <= 1'b1;
            test_tck    <= 1'b1;
            dbg_data_in <= 1'b1;
            rst_pad_out <= 1'b0;
            rst_pad_oe  <= 1'b0;
        end else begin
            test_tdi    <= test_en ? pad_in[`PFM_LN_TDI] : 1'b1;
            test_tms    <= test_en ? pad_in[`PFM_LN_TMS] : 1'b1;
            test_tck    <= test_en ? pad_in[`PFM_LN_TCK] : 1'b1;
            dbg_data_in <= dbg_link_en ? rst_pad_in : 1'b1;
            rst_pad_out <= dbg_link_en & dbg_data_out;
            rst_pad_oe  <= dbg_link_en & dbg_data_oe;
        end
    end

    assign test_port_en    = test_en;
    assign main_crystal_en = osc_ctrl[`PFM_OSC_MAIN];
    assign slow_crystal_en = osc_ctrl[`PFM_OSC_SLOW];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence dout_req_s;
        dbg_link_en && dbg_two_pin && !test_en;
    endsequence
    sequence dout_drive_s;
        pad_oe[`PFM_LN_DOUT] && pad_out[`PFM_LN_DOUT] == $past(debug_data_output);
    endsequence

    prio_d_wins_a: assert property (fn_en[3][3] |-> line_sel[3] == 4'h8)
        else $error("function d did not win on line 3");
    route_a_only_a: assert property (line_sel[5] == 4'h1 && !ovr[5] |=>
        pad_out[5] == $past(fn_a_out[5]) && pad_oe[5] == $past(fn_a_oe[5]))
        else $error("line 5 did not follow function a");
    gpio_fallback_a: assert property (!fn_any[5] |=>
        pad_out[5] == $past(gpio_out[5]) && pad_oe[5] == $past(gpio_oe[5]))
        else $error("idle line 5 did not follow gpio");
    test_tdo_own_a: assert property (test_en |=>
        pad_oe[`PFM_LN_TDO] && pad_out[`PFM_LN_TDO] == $past(test_tdo)
        && !pad_oe[`PFM_LN_TCK] && !pad_oe[`PFM_LN_TDI])
        else $error("test port did not own its pins");
    tck_capture_a: assert property ($rose(cap_done) |->
        test_en == !$past(pad_in[`PFM_LN_TCK]) && test_port_en == test_en)
        else $error("test enable not taken from tck at release");
    test_off_free_a: assert property (cap_done && !test_en && !fn_any[0] |=>
        pad_oe[`PFM_LN_TDI] == $past(gpio_oe[`PFM_LN_TDI]))
        else $error("disabled test pin not free");
    osc_own_a: assert property (osc_ctrl[`PFM_OSC_MAIN] |=>
        pad_analog[`PFM_LN_XIN_MAIN] && !pad_oe[`PFM_LN_XIN_MAIN] && !pad_oe[`PFM_LN_XOUT_MAIN])
        else $error("main crystal pins still muxed");
    dbg_data_gate_a: assert property (!dbg_link_en |=> !rst_pad_oe && dbg_data_in)
        else $error("debug data pin active while link off");
    dout_drive_a: assert property (dout_req_s |=> dout_drive_s)
        else $error("debug data output not driven on pb12");
    dout_gate_a: assert property (!dbg_two_pin && !test_en && !fn_any[`PFM_LN_DOUT] |=>
        pad_oe[`PFM_LN_DOUT] == $past(gpio_oe[`PFM_LN_DOUT]))
        else $error("pb12 taken without two-pin mode");
endmodule // pfm_mux

// ### tb/pfm_periph_model.sv
// peripheral, gpio controller and debug link drive model for the pin function mux
`timescale 1ns/1ps
module pfm_periph_model (
    // pattern and link control from the bench
    input  wire pfm_pkg::pfm_lines_t p,
    input  wire pfm_pkg::pfm_lines_t q,
    input  wire logic                link,
    input  wire logic                two,
    // gpio controller and functions a to d
    output      pfm_pkg::pfm_lines_t gpio_out,
    output      pfm_pkg::pfm_lines_t gpio_oe,
    output      pfm_pkg::pfm_lines_t fn_a_out,
    output      pfm_pkg::pfm_lines_t fn_a_oe,
    output      pfm_pkg::pfm_lines_t fn_b_out,
    output      pfm_pkg::pfm_lines_t fn_b_oe,
    output      pfm_pkg::pfm_lines_t fn_c_out,
    output      pfm_pkg::pfm_lines_t fn_c_oe,
    output      pfm_pkg::pfm_lines_t fn_d_out,
    output      pfm_pkg::pfm_lines_t fn_d_oe,
    // test port and debug link
    output      logic                test_tdo,
    output      logic                dbg_link_en,
    output      logic                dbg_two_pin,
    output      logic                dbg_data_out,
    output      logic                dbg_data_oe,
    output      logic                debug_data_output
);
    // each source gets its own out/oe signature
    assign gpio_out = p;
    assign gpio_oe  = q;
    assign fn_a_out = ~p;
    assign fn_a_oe  = q;
    assign fn_b_out = p;
    assign fn_b_oe  = ~q;
    assign fn_c_out = ~p;
    assign fn_c_oe  = ~q;
    assign fn_d_out = p ^ q;
    assign fn_d_oe  = '1;
    assign test_tdo = q[0];
    assign dbg_link_en       = link;
    // two-pin command only honoured once the link is up
    assign dbg_two_pin       = link & two;
    assign dbg_data_out      = p[0];
    assign dbg_data_oe       = q[1];
    assign debug_data_output = p[1];
endmodule // pfm_periph_model

// ### tb/pin_function_mux_tb_top.sv
// self-checking bench of the pin function mux
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; $display( \
    "wrong value %s expected %h seen %h", n, e, g); end end
module pin_function_mux_tb_top;
    logic                pclk = 1'b0;
    logic                presetn = 1'b0;
    logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]         paddr = 12'h0;
    logic [31:0]         pwdata = 32'h0;
    logic [31:0]         prdata;
    logic                pready, pslverr;
    pfm_pkg::pfm_lines_t p = '0, q = '0, pad_in = '1;
    pfm_pkg::pfm_lines_t gpio_out, gpio_oe, gpio_in, pad_out, pad_oe, pad_analog;
    pfm_pkg::pfm_lines_t fn_a_out, fn_a_oe, fn_a_in, fn_b_out, fn_b_oe, fn_b_in;
    pfm_pkg::pfm_lines_t fn_c_out, fn_c_oe, fn_c_in, fn_d_out, fn_d_oe, fn_d_in;
    logic                link = 1'b0, two = 1'b0, rst_pad_in = 1'b1, te = 1'b0;
    logic                dbg_link_en, dbg_two_pin, dbg_data_out, dbg_data_oe;
    logic                debug_data_output, test_tdo, test_port_en, test_tdi, test_tms;
    logic                test_tck, dbg_data_in, rst_pad_out, rst_pad_oe;
    logic                main_crystal_en, slow_crystal_en;
    logic [31:0]         seed = 32'h4a4ccac1;
    logic [31:0]         sh [9];
    int                  errors = 0, tests_run = 0;

    always #50 pclk = ~pclk;

    pfm_periph_model i_model (.*);
    pfm_mux i_dut (.*);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg();
        logic [31:0] rd, d, m;
        logic        er;
        for (int i = 0; i < 9; i++) begin
            m = i == 8 ? 32'h3 : (i % 2 ? 32'h7ffff : 32'hffffffff);
            apb(1'b0, 12'(i * 4), 32'h0, rd, er);
            `CHK("reg before write", sh[i], rd)
            d = rnd();
            apb(1'b1, 12'(i * 4), d, rd, er);
            sh[i] = d & m;
            apb(1'b0, 12'(i * 4), 32'h0, rd, er);
            `CHK("reg after write", sh[i], rd)
            `CHK("reg read error", 1'b0, er)
        end
        d = rnd();
        link <= d[0];
        two  <= d[1];
        apb(1'b1, 12'h024, 32'hffffffff, rd, er);
        `CHK("status write error", 1'b0, er)
        apb(1'b0, 12'h024, 32'h0, rd, er);
        `CHK("status", {28'h0, link & two & !te, link & two, link, te}, rd)
        apb(1'b1, 12'h028, d, rd, er);
        `CHK("unmapped write error", 1'b1, er)
        apb(1'b0, 12'h02c, 32'h0, rd, er);
        `CHK("unmapped read", 33'h100000000, {er, rd})
    endtask

    task automatic expect_pins(output pfm_pkg::pfm_lines_t eo, eoe, ea, ov);
        pfm_pkg::pfm_lines_t en [4];
        int                  s;
        for (int k = 0; k < 4; k++)
            en[k] = {sh[2 * k + 1][18:0], sh[2 * k]};
        for (int i = 0; i < 51; i++) begin
            s = 0;
            for (int k = 0; k < 4; k++)
                if (en[k][i]) s = k + 1;
            ea[i] = 1'b0;
            ov[i] = 1'b1;
            eo[i] = 1'b0;
            if (te && (i < 3 || i == 44)) begin
                eoe[i] = (i == 1);
                eo[i]  = (i == 1) & q[0];
            end else if (i == 44 && link && two) begin
                eoe[i] = 1'b1;
                eo[i]  = p[1];
            end else if ((sh[8][0] && (i == 18 || i == 19)) ||
                         (sh[8][1] && (i == 11 || i == 12))) begin
                eoe[i] = 1'b0;
                ea[i]  = 1'b1;
            end else begin
                ov[i]  = 1'b0;
                eoe[i] = (s == 4) | (s > 1 ? ~q[i] : q[i]);
                eo[i]  = (s == 4) ? p[i] ^ q[i] : ((s % 2) ? ~p[i] : p[i]);
            end
        end
    endtask

    task automatic traffic(input int n);
        pfm_pkg::pfm_lines_t eo, eoe, ea, ov, en_d;
        logic [31:0]         r;
        repeat (n) begin
            @(posedge pclk);
            p      <= 51'({rnd(), rnd()});
            q      <= 51'({rnd(), rnd()});
            pad_in <= 51'({rnd(), rnd()});
            r = rnd();
            rst_pad_in <= r[0];
            @(posedge pclk);
            #1;
            expect_pins(eo, eoe, ea, ov);
            en_d = {sh[7][18:0], sh[6]};
            `CHK("pad enables", eoe, pad_oe)
            `CHK("pad values", eo, pad_out)
            `CHK("analog pads", ea, pad_analog)
            `CHK("gpio input", pad_in, gpio_in)
            `CHK("fn d input", pad_in & en_d & ~ov, fn_d_in)
            `CHK("fn a input", pad_in & {sh[1][18:0], sh[0]} & ~ov, fn_a_in)
            `CHK("fn b input", pad_in & {sh[3][18:0], sh[2]} & ~ov, fn_b_in)
            `CHK("fn c input", pad_in & {sh[5][18:0], sh[4]} & ~ov, fn_c_in)
            r[2:0] = te ? {pad_in[0], pad_in[2], pad_in[44]} : 3'h7;
            `CHK("test inputs", r[2:0], {test_tdi, test_tms, test_tck})
            `CHK("debug input", link ? rst_pad_in : 1'b1, dbg_data_in)
            `CHK("reset pad", {link & q[1], link & p[0]}, {rst_pad_oe, rst_pad_out})
            `CHK("crystals", sh[8][1:0], {slow_crystal_en, main_crystal_en})
            `CHK("test enable", te, test_port_en)
        end
    endtask

    task automatic do_reset(input logic tck);
        @(posedge pclk);
        presetn    <= 1'b0;
        pad_in[44] <= tck;
        link       <= 1'b0;
        two        <= 1'b0;
        sh = '{default: 32'h0};
        te = !tck;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        sh = '{default: 32'h0};
        for (int t = 0; t < 2; t++) begin
            do_reset(t == 0);
            repeat (6) begin
                cfg();
                traffic(40);
            end
            $display("test %s done", te ? "test port on" : "test port off");
        end
        results();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("watchdog expired");
        results();
    end
endmodule // pin_function_mux_tb_top
